// File: pswg_cfg.svh
// constants for the power stage waveform generator
`ifndef PSWG_CFG_SVH
`define PSWG_CFG_SVH
`define PSWG_CW          12
`define PSWG_FRAC_W      4
`define PSWG_FOUR_DT_ADD 12'h002
`define PSWG_ONE_ADD     12'h001
`define PSWG_ZERO        12'h000
`define PSWG_MAXCNT      12'hfff
`endif

// File: pswg_pkg.sv
// types for the power stage waveform generator
package pswg_pkg;
  typedef enum logic [1:0] {
    PSWG_FOUR_RAMP = 2'h0,
    PSWG_TWO_RAMP  = 2'h1,
    PSWG_ONE_RAMP  = 2'h2,
    PSWG_CENTRE    = 2'h3
  } pswg_mode_e;

  typedef struct packed {
    logic [11:0] set_a;
    logic [11:0] rst_a;
    logic [11:0] set_b;
    logic [11:0] rst_b;
    logic [3:0]  frac;
    pswg_mode_e  mode;
    logic        fifty;
    logic        out2_from_b;
    logic        out3_from_b;
  } pswg_vals_s;
endpackage

// File: pswg_clk_pick.sv
// counter tick selection between i/o and pll clock enables
`timescale 1ns/1ps
`default_nettype none
module pswg_clk_pick (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // tick sources
  input  wire logic use_pll_i,
  input  wire logic io_tick_i,
  input  wire logic pll_tick_i,
  // selected tick
  output logic      tick_o
);
  logic sel_r;

  // selection follows use_pll_i one clock later, even while running: registered to avoid glitchy ticks
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_r <= 1'b0;
    end else begin
      sel_r <= use_pll_i;
    end
  end

  assign tick_o = sel_r ? pll_tick_i : io_tick_i;
endmodule
`default_nettype wire

// File: pswg_core.sv
// waveform core: counter, compare logic, deferred value update
`timescale 1ns/1ps
`default_nettype none
`include "pswg_cfg.svh"
module pswg_core #(
  parameter int CW = `PSWG_CW
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  // counter tick sources
  input  wire logic                 use_pll_i,
  input  wire logic                 io_tick_i,
  input  wire logic                 pll_tick_i,
  // control
  input  wire logic                 run_i,
  input  wire logic                 lock_i,
  input  wire logic                 auto_upd_i,
  input  wire logic                 third_inst_i,
  // staging writes
  input  wire logic                 wr_set_a_i,
  input  wire logic                 wr_rst_a_i,
  input  wire logic                 wr_set_b_i,
  input  wire logic                 wr_rst_b_i,
  input  wire logic                 wr_cfg_i,
  input  wire logic [15:0]          wr_data_i,
  input  wire pswg_pkg::pswg_mode_e wr_mode_i,
  input  wire logic                 wr_fifty_i,
  input  wire logic                 wr_out2_b_i,
  input  wire logic                 wr_out3_b_i,
  // events
  input  wire logic                 retrig_i,
  input  wire logic                 fault_i,
  input  wire logic                 sync_from_neighbour_i,
  input  wire logic                 halt_from_neighbour_i,
  // waveform outputs
  output logic                      wave_out_0_o,
  output logic                      wave_out_1_o,
  output logic                      wave_out_2_o,
  output logic                      wave_out_3_o,
  // status
  output logic [CW-1:0]             retrigger_capture_value_o,
  output logic [CW-1:0]             counter_o,
  output logic [3:0]                active_frac_o,
  output logic                      combined_irq_o,
  output logic                      converter_sync_strobe_o,
  output logic                      sync_to_neighbour_o,
  output logic                      halt_to_neighbour_o,
  output logic                      cycle_end_o
);
  pswg_pkg::pswg_vals_s stage_r;
  pswg_pkg::pswg_vals_s act_r;
  logic [CW-1:0]        cnt_r;
  logic                 part_b_r;
  logic                 down_r;
  logic                 last_rb_r;
  logic                 auto_eff_r;
  logic                 out0_r;
  logic                 out1_r;
  logic                 tick;
  logic                 running;
  logic                 end_a;
  logic                 end_b;
  logic                 upd;
  logic [CW-1:0]        sa;
  logic [CW-1:0]        ra;
  logic [CW-1:0]        sb;
  logic [CW-1:0]        rb;
  logic [CW-1:0]        lim_a;
  logic [CW-1:0]        lim_b;

  pswg_clk_pick u_pick (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .use_pll_i  (use_pll_i),
    .io_tick_i  (io_tick_i),
    .pll_tick_i (pll_tick_i),
    .tick_o     (tick)
  );

  // fifty mode mirrors part B values onto part A
  assign sa = act_r.fifty ? act_r.set_b : act_r.set_a;
  assign ra = act_r.fifty ? act_r.rst_b : act_r.rst_a;
  assign sb = act_r.set_b;
  assign rb = act_r.rst_b;

  // ramp end points per sub-cycle
  always_comb begin
    lim_a = `PSWG_ZERO;
    lim_b = `PSWG_ZERO;
    unique case (act_r.mode)
      pswg_pkg::PSWG_FOUR_RAMP: begin
        // dead time set+2 then on time reset: last count is one less
        lim_a = sa + ra + `PSWG_FOUR_DT_ADD - `PSWG_ONE_ADD;
        lim_b = sb + rb + `PSWG_FOUR_DT_ADD - `PSWG_ONE_ADD;
      end
      pswg_pkg::PSWG_TWO_RAMP: begin
        lim_a = ra;
        lim_b = rb;
      end
      pswg_pkg::PSWG_ONE_RAMP: begin
        lim_a = rb;
        lim_b = rb;
      end
      pswg_pkg::PSWG_CENTRE: begin
        lim_a = rb;
        lim_b = rb;
      end
    endcase
  end

  assign running = run_i & ~halt_from_neighbour_i;
  assign end_a   = tick & running & ~part_b_r & (cnt_r == lim_a) &
                   (act_r.mode != pswg_pkg::PSWG_ONE_RAMP) &
                   (act_r.mode != pswg_pkg::PSWG_CENTRE);
  // one ramp and centre end the cycle on a single ramp
  assign end_b   = tick & running & (
                   (act_r.mode == pswg_pkg::PSWG_CENTRE) ?
                   (down_r & (cnt_r == `PSWG_ZERO)) :
                   (((act_r.mode == pswg_pkg::PSWG_ONE_RAMP) | part_b_r) &
                    (cnt_r == lim_b)));
  // auto-update wins over lock
  assign upd = end_b & (auto_eff_r ? last_rb_r : ~lock_i);
  assign cycle_end_o = end_b;

  // staging registers written by software
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage_r <= '0;
    end else begin
      if (wr_set_a_i) stage_r.set_a <= wr_data_i[11:0];
      if (wr_rst_a_i) stage_r.rst_a <= wr_data_i[11:0];
      if (wr_set_b_i) stage_r.set_b <= wr_data_i[11:0];
      if (wr_rst_b_i) begin
        stage_r.rst_b <= wr_data_i[11:0];
        stage_r.frac  <= wr_data_i[15:12];
      end
      if (wr_cfg_i) begin
        stage_r.mode        <= wr_mode_i;
        stage_r.fifty       <= wr_fifty_i;
        stage_r.out2_from_b <= wr_out2_b_i;
        stage_r.out3_from_b <= wr_out3_b_i;
      end
    end
  end

  // part A reset is not covered by deferral: it goes straight through
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      act_r <= '0;
    end else begin
      if (upd) begin
        act_r.set_a       <= stage_r.set_a;
        act_r.set_b       <= stage_r.set_b;
        act_r.rst_b       <= stage_r.rst_b;
        act_r.frac        <= stage_r.frac;
        act_r.mode        <= stage_r.mode;
        act_r.fifty       <= stage_r.fifty;
        act_r.out2_from_b <= stage_r.out2_from_b;
        act_r.out3_from_b <= stage_r.out3_from_b;
      end
      if (wr_rst_a_i) begin
        act_r.rst_a <= wr_data_i[11:0];
      end
    end
  end

  // last-written tracking for auto-update
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      last_rb_r <= 1'b0;
    end else if (wr_rst_b_i) begin
      last_rb_r <= 1'b1;
    end else if (wr_set_a_i | wr_rst_a_i | wr_set_b_i | wr_cfg_i | upd) begin
      last_rb_r <= 1'b0;
    end
  end

  // auto-update selection sampled only at cycle end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      auto_eff_r <= 1'b0;
    end else if (end_b) begin
      auto_eff_r <= auto_upd_i;
    end
  end

  // counter and sub-cycle sequencing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r    <= `PSWG_ZERO;
      part_b_r <= 1'b0;
      down_r   <= 1'b0;
    end else if (!running) begin
      cnt_r    <= `PSWG_ZERO;
      part_b_r <= 1'b0;
      down_r   <= 1'b0;
    end else if (tick) begin
      if (act_r.mode == pswg_pkg::PSWG_CENTRE) begin
        // up to limit, then down to zero
        if (!down_r && cnt_r == lim_b) begin
          // top value held twice so the cycle spans 2*(rb+1) ticks
          down_r <= 1'b1;
          cnt_r  <= cnt_r;
        end else if (end_b) begin
          down_r <= 1'b0;
          cnt_r  <= `PSWG_ZERO;
        end else if (down_r) begin
          cnt_r <= cnt_r - `PSWG_ONE_ADD;
        end else begin
          cnt_r <= cnt_r + `PSWG_ONE_ADD;
        end
      end else if (retrig_i) begin
        cnt_r <= `PSWG_ZERO;
        if (act_r.mode != pswg_pkg::PSWG_ONE_RAMP) begin
          part_b_r <= ~part_b_r;
        end
      end else if (end_a) begin
        cnt_r    <= `PSWG_ZERO;
        part_b_r <= 1'b1;
      end else if (end_b) begin
        cnt_r    <= `PSWG_ZERO;
        part_b_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + `PSWG_ONE_ADD;
      end
    end
  end

  // output compares; dead time precedes on time in each sub-cycle, except output 0 in centre mode, which is on from count zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out0_r <= 1'b0;
      out1_r <= 1'b0;
    end else if (!running) begin
      out0_r <= 1'b0;
      out1_r <= 1'b0;
    end else begin
      unique case (act_r.mode)
        pswg_pkg::PSWG_FOUR_RAMP: begin
          out0_r <= ~part_b_r & (cnt_r > sa + `PSWG_ONE_ADD);
          out1_r <= part_b_r & (cnt_r > sb + `PSWG_ONE_ADD);
        end
        pswg_pkg::PSWG_TWO_RAMP: begin
          out0_r <= ~part_b_r & (cnt_r >= sa) & (cnt_r < ra);
          out1_r <= part_b_r & (cnt_r >= sb) & (cnt_r < rb);
        end
        pswg_pkg::PSWG_ONE_RAMP: begin
          out0_r <= (cnt_r >= sa) & (cnt_r < ra);
          out1_r <= (cnt_r >= sb) & (cnt_r < rb);
        end
        pswg_pkg::PSWG_CENTRE: begin
          // ra unused here: only the strobe looks at it
          out0_r <= (cnt_r < sa);
          out1_r <= (cnt_r >= sb);
        end
      endcase
    end
  end

  // output routing; extra outputs only on the third instance
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wave_out_0_o <= 1'b0;
      wave_out_1_o <= 1'b0;
      wave_out_2_o <= 1'b0;
      wave_out_3_o <= 1'b0;
    end else begin
      wave_out_0_o <= out0_r;
      wave_out_1_o <= out1_r;
      wave_out_2_o <= third_inst_i & (act_r.out2_from_b ? out1_r : out0_r);
      wave_out_3_o <= third_inst_i & (act_r.out3_from_b ? out1_r : out0_r);
    end
  end

  // capture, interrupt and neighbour signals
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      retrigger_capture_value_o <= `PSWG_ZERO;
      combined_irq_o            <= 1'b0;
      converter_sync_strobe_o   <= 1'b0;
      sync_to_neighbour_o       <= 1'b0;
      halt_to_neighbour_o       <= 1'b0;
    end else begin
      if (retrig_i) begin
        retrigger_capture_value_o <= cnt_r;
      end
      combined_irq_o          <= end_b | fault_i | retrig_i;
      converter_sync_strobe_o <= running & (cnt_r == ra);
      sync_to_neighbour_o     <= end_b | sync_from_neighbour_i;
      halt_to_neighbour_o     <= ~running;
    end
  end

  assign counter_o     = cnt_r;
  assign active_frac_o = act_r.frac;
endmodule
`default_nettype wire

// File: pswg_checker.sv
// port-level assertions for the waveform core
`timescale 1ns/1ps
`default_nettype none
module pswg_checker #(
  parameter int CW = 12
) (
  // clock, reset and controls
  input wire logic                 clk_i,
  input wire logic                 srst_i,
  input wire logic                 run_i,
  input wire logic                 third_inst_i,
  input wire logic                 retrig_i,
  input wire logic                 fault_i,
  input wire logic                 wr_cfg_i,
  input wire pswg_pkg::pswg_mode_e wr_mode_i,
  // outputs watched
  input wire logic                 wave_out_0_o,
  input wire logic                 wave_out_1_o,
  input wire logic                 wave_out_2_o,
  input wire logic                 wave_out_3_o,
  input wire logic [CW-1:0]        retrigger_capture_value_o,
  input wire logic [CW-1:0]        counter_o,
  input wire logic                 combined_irq_o,
  input wire logic                 sync_to_neighbour_o,
  input wire logic                 halt_to_neighbour_o,
  input wire logic                 converter_sync_strobe_o,
  input wire logic                 cycle_end_o
);
  // sticky: overlap is legal once one-ramp has been staged
  logic one_seen_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) one_seen_r <= 1'b0;
    else if (wr_cfg_i && wr_mode_i == pswg_pkg::PSWG_ONE_RAMP) one_seen_r <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_reset_clears: assert property ($fell(srst_i) |-> counter_o == '0 && !wave_out_0_o)
    else $error("outputs not clear after reset");
  a_halt_clears: assert property (!run_i ##1 !run_i |=>
    counter_o == '0 && !wave_out_0_o && !wave_out_1_o)
    else $error("halt did not clear counter and outputs");
  a_halt_flag: assert property (!run_i |=> halt_to_neighbour_o)
    else $error("halt not passed to neighbour");
  a_strobe_quiet: assert property (!run_i |=> !converter_sync_strobe_o)
    else $error("converter strobe while halted");
  a_capture_count: assert property (retrig_i |=> retrigger_capture_value_o == $past(counter_o))
    else $error("capture value differs from counter");
  a_irq_raise: assert property (fault_i || retrig_i || cycle_end_o |=> combined_irq_o)
    else $error("irq missing after source");
  a_irq_cause: assert property (combined_irq_o |-> $past(fault_i || retrig_i || cycle_end_o))
    else $error("irq without source");
  a_no_overlap: assert property (!one_seen_r |-> !(wave_out_0_o && wave_out_1_o))
    else $error("both outputs on outside one-ramp");
  a_dup_off: assert property (!third_inst_i |=> !wave_out_2_o && !wave_out_3_o)
    else $error("extra outputs active off third instance");
  a_end_sync: assert property (cycle_end_o |=> sync_to_neighbour_o)
    else $error("no sync pulse after cycle end");
  c_cycle_end: cover property (cycle_end_o);
  c_retrig_irq: cover property (retrig_i ##1 combined_irq_o);
  c_overlap: cover property (wave_out_0_o && wave_out_1_o);
  c_dup_on: cover property (third_inst_i && wave_out_2_o);
endmodule
bind pswg_core pswg_checker #(.CW(CW)) u_chk (
  .clk_i, .srst_i, .run_i, .third_inst_i, .retrig_i, .fault_i, .wr_cfg_i, .wr_mode_i,
  .wave_out_0_o, .wave_out_1_o, .wave_out_2_o, .wave_out_3_o, .retrigger_capture_value_o,
  .counter_o, .combined_irq_o, .sync_to_neighbour_o, .cycle_end_o,
  .halt_to_neighbour_o, .converter_sync_strobe_o
);
`default_nettype wire

// File: pswg_bridge_model.sv
// half bridge load model timing gate pulses per cycle
`timescale 1ns/1ps
`default_nettype none
module pswg_bridge_model (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   srst_i,
  // gate drive and cycle marker
  input  wire logic   gate_a_i,
  input  wire logic   gate_b_i,
  input  wire logic   cycle_end_i,
  // spans of the last whole cycle
  output logic [15:0] period_o,
  output logic [15:0] on_a_o,
  output logic [15:0] on_b_o
);
  logic [15:0] cnt_r;
  logic [15:0] a_r;
  logic [15:0] b_r;
  // window runs end to end, so output lag does not bias steady counts
  always_ff @(posedge clk_i) begin
    cnt_r <= (srst_i || cycle_end_i) ? 16'h0000 : cnt_r + 16'h0001;
    a_r   <= (srst_i || cycle_end_i) ? 16'h0000 : a_r + 16'(gate_a_i);
    b_r   <= (srst_i || cycle_end_i) ? 16'h0000 : b_r + 16'(gate_b_i);
    if (cycle_end_i) begin
      period_o <= cnt_r + 16'h0001;
      on_a_o   <= a_r + 16'(gate_a_i);
      on_b_o   <= b_r + 16'(gate_b_i);
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the waveform core
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic                 clk_i, srst_i, use_pll, run, lock, auto_upd;
  logic                 pll_tick = 1'b0;
  logic                 third, fifty, o2b, o3b, retrig, fault;
  logic                 w0, w1, w2, w3, ce, irq, strb;
  logic [4:0]           stb;
  logic [15:0]          wd, per, hi0, hi1;
  logic [11:0]          cnt;
  logic [3:0]           frac;
  pswg_pkg::pswg_mode_e mode;
  int                   n_fail, checks_done, mism;
  pswg_pkg::pswg_mode_e mt [4] = '{pswg_pkg::PSWG_FOUR_RAMP, pswg_pkg::PSWG_TWO_RAMP,
                                   pswg_pkg::PSWG_CENTRE, pswg_pkg::PSWG_ONE_RAMP};
  pswg_core u_dut (
    .clk_i, .srst_i, .use_pll_i(use_pll), .io_tick_i(1'b1), .pll_tick_i(pll_tick),
    .run_i(run), .lock_i(lock), .auto_upd_i(auto_upd), .third_inst_i(third),
    .wr_set_a_i(stb[0]), .wr_rst_a_i(stb[1]), .wr_set_b_i(stb[2]), .wr_rst_b_i(stb[3]),
    .wr_cfg_i(stb[4]), .wr_data_i(wd), .wr_mode_i(mode), .wr_fifty_i(fifty),
    .wr_out2_b_i(o2b), .wr_out3_b_i(o3b), .retrig_i(retrig), .fault_i(fault),
    .sync_from_neighbour_i(1'b0), .halt_from_neighbour_i(1'b0),
    .wave_out_0_o(w0), .wave_out_1_o(w1), .wave_out_2_o(w2), .wave_out_3_o(w3),
    .retrigger_capture_value_o(), .counter_o(cnt), .active_frac_o(frac),
    .combined_irq_o(irq), .converter_sync_strobe_o(strb), .sync_to_neighbour_o(),
    .halt_to_neighbour_o(), .cycle_end_o(ce)
  );
  pswg_bridge_model u_load (
    .clk_i, .srst_i, .gate_a_i(w0), .gate_b_i(w1), .cycle_end_i(ce),
    .period_o(per), .on_a_o(hi0), .on_b_o(hi1)
  );
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // half-rate pll tick, only counts while selected
  always @(negedge clk_i) pll_tick <= ~pll_tick;
  // {period, on a, on b} in clock periods
  function automatic logic [47:0] spans(input pswg_pkg::pswg_mode_e m,
                                        input logic [15:0] sa, ra, sb, rb);
    case (m)
      pswg_pkg::PSWG_FOUR_RAMP: return {ra + sa + rb + sb + 16'h0004, ra, rb};
      pswg_pkg::PSWG_TWO_RAMP:  return {ra + rb + 16'h0002, ra - sa, rb - sb};
      pswg_pkg::PSWG_ONE_RAMP:  return {rb + 16'h0001, ra - sa, rb - sb};
      default:                  return {rb + rb + 16'h0002, sa + sa, (rb - sb + 16'h0001) << 1};
    endcase
  endfunction
  task automatic w(input int k, input logic [15:0] d);
    @(negedge clk_i);
    stb = 5'h01 << k;
    wd = d;
    @(negedge clk_i);
    stb = 5'h00;
  endtask
  task automatic prog(input pswg_pkg::pswg_mode_e m, input logic [15:0] sa, ra, sb, rb);
    mode = m;
    w(4, 16'h0000);
    w(0, sa);
    w(1, ra);
    w(2, sb);
    w(3, rb);
  endtask
  task automatic ends(input int n);
    int t;
    t = 0;
    repeat (n) begin
      @(negedge clk_i);
      while (ce !== 1'b1 && t < 2000) begin
        @(negedge clk_i);
        t++;
      end
    end
    if (t >= 2000) n_fail++;
  endtask
  // third cycle end gives a window free of the update transient
  task automatic meas(input logic [47:0] e);
    ends(3);
    @(negedge clk_i);
    `CHK("period", e[47:32], per)
    `CHK("on_time_a", e[31:16], hi0)
    `CHK("on_time_b", e[15:0], hi1)
  endtask
  task automatic results();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {use_pll, run, lock, auto_upd, third, fifty, o2b, o3b, retrig, fault, stb, wd} = '0;
    mode = pswg_pkg::PSWG_TWO_RAMP;
    srst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    srst_i = 1'b0;
    `CHK("counter", 12'h000, cnt)
    run = 1'b1;
    prog(pswg_pkg::PSWG_TWO_RAMP, 16'h0001, 16'h0003, 16'h0001, 16'h0003);
    meas(spans(pswg_pkg::PSWG_TWO_RAMP, 16'h0001, 16'h0003, 16'h0001, 16'h0003));
    lock = 1'b1;
    w(3, 16'h0007);
    meas(spans(pswg_pkg::PSWG_TWO_RAMP, 16'h0001, 16'h0003, 16'h0001, 16'h0003));
    lock = 1'b0;
    meas(spans(pswg_pkg::PSWG_TWO_RAMP, 16'h0001, 16'h0003, 16'h0001, 16'h0007));
    {auto_upd, lock} = 2'h3;
    ends(2);
    w(3, 16'h0003);
    w(2, 16'h0002);
    meas(spans(pswg_pkg::PSWG_TWO_RAMP, 16'h0001, 16'h0003, 16'h0001, 16'h0007));
    w(3, 16'h0005);
    meas(spans(pswg_pkg::PSWG_TWO_RAMP, 16'h0001, 16'h0003, 16'h0002, 16'h0005));
    {auto_upd, lock, fifty} = 3'h1;
    prog(pswg_pkg::PSWG_TWO_RAMP, 16'h0000, 16'h0000, 16'h0002, 16'h5006);
    meas(spans(pswg_pkg::PSWG_TWO_RAMP, 16'h0002, 16'h0006, 16'h0002, 16'h0006));
    `CHK("frac", 4'h5, frac)
    {fifty, third, o2b} = 3'h3;
    prog(pswg_pkg::PSWG_TWO_RAMP, 16'h0001, 16'h0003, 16'h0002, 16'h0005);
    ends(2);
    mism = 0;
    repeat (16) begin
      @(negedge clk_i);
      if (w2 !== w1 || w3 !== w0) mism++;
    end
    `CHK("duplicates", 0, mism)
    use_pll = 1'b1;
    meas(spans(pswg_pkg::PSWG_TWO_RAMP, 16'h0001, 16'h0003, 16'h0002, 16'h0005) << 1);
    use_pll = 1'b0;
    fault = 1'b1;
    @(negedge clk_i);
    {fault, retrig} = 2'h1;
    @(negedge clk_i);
    retrig = 1'b0;
    `CHK("irq", 1'b1, irq)
    run = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK("halted", 14'h0000, {cnt, w0, w1})
    run = 1'b1;
    for (int i = 0; i < 4; i++) begin
      prog(mt[i], 16'h0002, 16'h0005, 16'h0003, 16'h0009);
      meas(spans(mt[i], 16'h0002, 16'h0005, 16'h0003, 16'h0009));
    end
    // one-ramp still active: strobe follows the part A reset match
    while (cnt !== 12'h005) @(negedge clk_i);
    @(negedge clk_i);
    `CHK("sync_strobe", 1'b1, strb)
    @(negedge clk_i);
    `CHK("sync_strobe_end", 1'b0, strb)
    results();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
